// ### core/ocdac_regs.sv
// serial register bank of an eight channel 16-bit converter
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: writing one to bit 15 of the sleep control register enters serial sleep; zero keeps normal mode.
// RULE2: the sleep bit clears on hardware reset and whenever the resume pin is low.
// RULE3: in normal mode serial input bits are shifted into the shift register.
// RULE4: in sleep mode the shift register is bypassed and serial input goes straight to serial output.
// RULE5: a write to address 07h loads its sixteen data bits into all eight channel registers at once.
// RULE6: the broadcast write only acts while the correction-engine select is zero and is ignored otherwise.
// RULE7: the broadcast register is write-only and reads back as zero.
// RULE8: with correction-engine select one, the input code passes through the correction engine.
// RULE9: with correction-engine select zero, the written code is the channel data directly.
// RULE10: a channel output changes only when its data is transferred into the output latch.
// RULE11: every channel input register resets to zero.
// RULE12: each offset trim register holds a sixteen-bit two's-complement correction of one code per step.
// RULE13: the offset trim spans 8000h to 7fffh and defaults to zero.
// RULE14: each gain trim register holds a sixteen-bit straight-binary gain coefficient.
// RULE15: gain code 0000h means 0.5, 8000h unity (default) and ffffh 1.499985.
// RULE16: with the resume option set and resume pin high, a chip-select rise after at most one clock fall wakes the part.
// RULE17: while the resume pin is low the resume option is ignored and the part stays in normal mode.
module ocdac_regs
  import ocdac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // serial port
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // control pins
  input wire logic resume_pin_n_i,
  input wire logic load_n_i,
  // channel output latches and status
  output logic [DATA_W-1:0] chan_latch_o [NCH],
  output logic serial_sleep_o
);

  ////////////////////////////////////////////////////////////////////////////
  // correction engine: code * (gain + half) / 2^16 + offset, clamped to the code range
  function automatic logic [DATA_W-1:0] correct_code(
    input logic [DATA_W-1:0] code,
    input logic [DATA_W-1:0] offset,
    input logic [DATA_W-1:0] gain
  );
    logic [PROD_W-1:0] prod;
    logic signed [SUM_W-1:0] sum;
    prod = PROD_W'(code) * (PROD_W'(gain) + PROD_W'(GAIN_BIAS));
    sum = $signed({2'b00, prod[PROD_W-1:GAIN_FRAC]})
      + $signed({{3{offset[DATA_W-1]}}, offset});
    if (sum < 0)
      correct_code = READ_ZERO;
    else if (sum > $signed({3'b000, CODE_MAX}))
      correct_code = CODE_MAX;
    else
      correct_code = sum[DATA_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic sclk_q;
  logic cs_n_q;
  logic [CNT_W-1:0] fall_cnt_q;
  logic [FRAME_W-1:0] shift_q;
  logic sdo_q;
  logic sleep_q;
  logic sce_q;
  logic w2_q;
  logic [DATA_W-1:0] code_q [NCH];
  logic [DATA_W-1:0] offset_q [NCH];
  logic [DATA_W-1:0] gain_q [NCH];
  logic [DATA_W-1:0] latch_q [NCH];
  logic [DATA_W-1:0] chan_data [NCH];

  ////////////////////////////////////////////////////////////////////////////
  // pin edges; inputs are already synchronous to sys_clk_i
  wire sclk_fall = sclk_q & ~sclk_i;
  wire sclk_rise = ~sclk_q & sclk_i;
  wire cs_fall = cs_n_q & ~cs_n_i;
  wire cs_rise = ~cs_n_q & cs_n_i;
  wire shift_en = sclk_fall & ~cs_n_i & ~sleep_q;

  // frame decode, only a complete frame outside sleep counts
  wire frame_done = cs_rise & ~sleep_q & (fall_cnt_q == FRAME_BITS);
  wire fr_read = shift_q[FR_RW_BIT];
  wire [ADDR_W-1:0] fr_addr = shift_q[FR_ADDR_HI:FR_ADDR_LO];
  wire [DATA_W-1:0] fr_data = shift_q[DATA_W-1:0];
  wire wr_en = frame_done & ~fr_read;
  wire rd_en = frame_done & fr_read;
  wire [1:0] fr_region = fr_addr[ADDR_W-1:CH_W];
  wire [CH_W-1:0] fr_ch = fr_addr[CH_W-1:0];

  // write strobes per register group
  wire wr_config = wr_en & (fr_addr == ADDR_CONFIG);
  wire wr_sleep = wr_en & (fr_addr == ADDR_SLEEP_CTRL);
  wire wr_bcast = wr_en & (fr_addr == ADDR_BROADCAST) & ~sce_q; // RULE6
  wire wr_code = wr_en & (fr_region == REGION_CODE);
  wire wr_offset = wr_en & (fr_region == REGION_OFFSET);
  wire wr_gain = wr_en & (fr_region == REGION_GAIN);

  // wake by chip select: the resume pin must be high for this path
  wire cs_wake = cs_rise & sleep_q & w2_q & resume_pin_n_i
    & (fall_cnt_q <= WAKE_MAX_FALLS); // RULE16 RULE17

  ////////////////////////////////////////////////////////////////////////////
  // read data mux; broadcast and unmapped addresses read as zero
  wire [DATA_W-1:0] cfg_rd = DATA_W'({sce_q, 3'b000, w2_q, 4'b0000});
  wire [DATA_W-1:0] sleep_rd = {sleep_q, 15'h0000};
  wire [DATA_W-1:0] rd_data =
    (fr_addr == ADDR_CONFIG) ? cfg_rd :
    (fr_addr == ADDR_SLEEP_CTRL) ? sleep_rd :
    (fr_region == REGION_CODE) ? code_q[fr_ch] :
    (fr_region == REGION_OFFSET) ? offset_q[fr_ch] :
    (fr_region == REGION_GAIN) ? gain_q[fr_ch] :
    READ_ZERO; // RULE7

  // sleep next value: the resume pin outranks every set
  wire sleep_d = ~resume_pin_n_i ? 1'b0 : // RULE2 RULE17
    cs_wake ? 1'b0 : // RULE16
    wr_sleep ? fr_data[SLEEP_BIT] : // RULE1
    sleep_q;

  ////////////////////////////////////////////////////////////////////////////
  // edge history and clock fall counter for the current chip-select low phase
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      fall_cnt_q <= '0;
    end
    else
    begin
      sclk_q <= sclk_i;
      cs_n_q <= cs_n_i;
      if (cs_fall)
        fall_cnt_q <= '0;
      else if (sclk_fall & ~cs_n_i & (fall_cnt_q != CNT_MAX))
        fall_cnt_q <= fall_cnt_q + 5'h01;
    end
  end

  // shift register; a read reloads it so the next frame carries the answer out
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      shift_q <= '0;
    else if (rd_en)
      shift_q <= {RD_PAD, rd_data};
    else if (shift_en)
      shift_q <= {shift_q[FRAME_W-2:0], sdi_i}; // RULE3
  end

  // serial output: bypass in sleep, otherwise chain the shift register msb
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sdo_q <= 1'b0;
    else if (sleep_q)
      sdo_q <= sdi_i; // RULE4
    else if (sclk_rise | cs_fall)
      sdo_q <= shift_q[FRAME_W-1];
  end

  // control bits
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sleep_q <= 1'b0; // RULE2
      sce_q <= 1'b0;
      w2_q <= 1'b0;
    end
    else
    begin
      sleep_q <= sleep_d;
      if (wr_config)
      begin
        sce_q <= fr_data[SCE_BIT];
        w2_q <= fr_data[W2_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel registers; a broadcast touches only the input codes
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        code_q[i] <= CODE_RST; // RULE11
        offset_q[i] <= OFFSET_RST; // RULE13
        gain_q[i] <= GAIN_RST; // RULE15
      end
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (wr_bcast)
          code_q[i] <= fr_data; // RULE5
        else if (wr_code & (fr_ch == CH_W'(i)))
          code_q[i] <= fr_data;
        if (wr_offset & (fr_ch == CH_W'(i)))
          offset_q[i] <= fr_data; // RULE12
        if (wr_gain & (fr_ch == CH_W'(i)))
          gain_q[i] <= fr_data; // RULE14
      end
    end
  end

  // channel data: direct code, or corrected code when the engine is selected
  for (genvar g = 0; g < NCH; g++)
  begin : g_chan
    assign chan_data[g] = sce_q ? correct_code(code_q[g], offset_q[g], gain_q[g]) // RULE8
      : code_q[g]; // RULE9
  end

  // output latches follow the channel data only while load is held low
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NCH; i++)
        latch_q[i] <= CODE_RST;
    end
    else if (!load_n_i)
    begin
      for (int i = 0; i < NCH; i++)
        latch_q[i] <= chan_data[i]; // RULE10
    end
  end

  assign sdo_o = sdo_q;
  assign serial_sleep_o = sleep_q;
  assign chan_latch_o = latch_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_sleep_set;
    wr_sleep & fr_data[SLEEP_BIT] & resume_pin_n_i |=> sleep_q;
  endproperty
  a_sleep_set: assert property (p_sleep_set) else $error("sleep write did not set sleep"); // RULE1

  property p_resume_low;
    !resume_pin_n_i |=> !sleep_q;
  endproperty
  a_resume_low: assert property (p_resume_low) else $error("sleep held with resume low"); // RULE2

  property p_shift_in;
    shift_en & !rd_en |=> shift_q[0] == $past(sdi_i) && shift_q[FRAME_W-1:1] == $past(shift_q[FRAME_W-2:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in"); // RULE3

  property p_bypass;
    sleep_q ##1 sleep_q |-> sdo_o == $past(sdi_i) && $stable(shift_q);
  endproperty
  a_bypass: assert property (p_bypass) else $error("sleep did not bypass shift register"); // RULE4

  property p_bcast;
    wr_en & (fr_addr == ADDR_BROADCAST) & !sce_q |=>
      code_q[0] == $past(fr_data) && code_q[NCH-1] == $past(fr_data);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast did not load all channels"); // RULE5

  property p_bcast_ignored;
    wr_en & (fr_addr == ADDR_BROADCAST) & sce_q |=> $stable(code_q[0]) && $stable(code_q[NCH-1]);
  endproperty
  a_bcast_ignored: assert property (p_bcast_ignored) else $error("broadcast acted with engine on"); // RULE6

  property p_bcast_read;
    rd_en & (fr_addr == ADDR_BROADCAST) |=> shift_q == {RD_PAD, READ_ZERO};
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("broadcast read not zero"); // RULE7

  property p_direct;
    !sce_q |-> chan_data[0] == code_q[0] && chan_data[NCH-1] == code_q[NCH-1];
  endproperty
  a_direct: assert property (p_direct) else $error("direct path altered the code"); // RULE9

  property p_latch_hold;
    load_n_i[*2] |-> $stable(chan_latch_o[0]) && $stable(chan_latch_o[NCH-1]);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("output moved without load"); // RULE10

  property p_latch_load;
    !load_n_i |=> chan_latch_o[0] == $past(chan_data[0]);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("load did not transfer data"); // RULE10

  property p_cs_wake;
    cs_rise & sleep_q & w2_q & resume_pin_n_i & (fall_cnt_q <= WAKE_MAX_FALLS) |=> !sleep_q;
  endproperty
  a_cs_wake: assert property (p_cs_wake) else $error("chip select wake failed"); // RULE16

  property p_no_wake;
    sleep_q & resume_pin_n_i & (!w2_q | (fall_cnt_q > WAKE_MAX_FALLS)) & !wr_sleep |=> sleep_q;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke without a valid wake"); // RULE16

  // stored words follow their frame; the index is the channel of that frame
  property p_code_store;
    wr_code & sce_q |=> code_q[$past(fr_ch)] == $past(fr_data);
  endproperty
  a_code_store: assert property (p_code_store) else $error("engine code not stored"); // RULE8

  property p_offset_store;
    wr_offset |=> offset_q[$past(fr_ch)] == $past(fr_data);
  endproperty
  a_offset_store: assert property (p_offset_store) else $error("offset trim not stored"); // RULE12

  property p_gain_store;
    wr_gain |=> gain_q[$past(fr_ch)] == $past(fr_data);
  endproperty
  a_gain_store: assert property (p_gain_store) else $error("gain trim not stored"); // RULE14

  // correction end points: unity and half gain, and a negative offset never raises the code
  property p_gain_unity;
    sce_q & (gain_q[0] == GAIN_RST) & (offset_q[0] == OFFSET_RST) |-> chan_data[0] == code_q[0];
  endproperty
  a_gain_unity: assert property (p_gain_unity) else $error("unity gain altered the code"); // RULE15

  property p_gain_half;
    sce_q & (gain_q[1] == '0) & (offset_q[1] == OFFSET_RST) |->
      chan_data[1] == {1'b0, code_q[1][DATA_W-1:1]};
  endproperty
  a_gain_half: assert property (p_gain_half) else $error("zero gain code did not halve"); // RULE15

  property p_offset_down;
    sce_q & offset_q[2][DATA_W-1] & (gain_q[2] == GAIN_RST) |-> (chan_data[2] <= code_q[2]);
  endproperty
  a_offset_down: assert property (p_offset_down) else $error("negative trim raised code"); // RULE13

endmodule // ocdac_regs
`default_nettype wire

// ### core/ocdac_pkg.sv
// constants shared by the octal converter register bank
package ocdac_pkg;
  // serial frame layout: rw flag, two spare bits, address, data
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned FRAME_W = 24;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned NCH = 8;
  localparam int unsigned CH_W = 3;
  localparam int unsigned FR_RW_BIT = 23;
  localparam int unsigned FR_ADDR_HI = 20;
  localparam int unsigned FR_ADDR_LO = 16;
  localparam int unsigned RD_PAD_W = FRAME_W - DATA_W;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  localparam logic [CNT_W-1:0] WAKE_MAX_FALLS = 5'h01;
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_BROADCAST = 5'h07;
  localparam logic [1:0] REGION_CODE = 2'h1;
  localparam logic [1:0] REGION_OFFSET = 2'h2;
  localparam logic [1:0] REGION_GAIN = 2'h3;
  // field positions
  localparam int unsigned SLEEP_BIT = 15;
  localparam int unsigned SCE_BIT = 8;
  localparam int unsigned W2_BIT = 4;
  // reset values
  localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] OFFSET_RST = 16'h0000;
  localparam logic [DATA_W-1:0] GAIN_RST = 16'h8000;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
  localparam logic [RD_PAD_W-1:0] RD_PAD = 8'h00;
  // correction arithmetic: coefficient is one half plus gain over 2^16, so the
  // gain is biased by one half before the product and sixteen fraction bits drop
  localparam int unsigned PROD_W = 33;
  localparam int unsigned GAIN_FRAC = 16;
  localparam logic [DATA_W-1:0] GAIN_BIAS = 16'h8000;
  localparam int unsigned SUM_W = 19;
  localparam logic [DATA_W-1:0] CODE_MAX = 16'hffff;
endpackage

// ### tb/ocdac_host.sv
// serial host model that frames reads and writes toward the register bank
`timescale 1ns/100ps
`default_nettype none
module ocdac_host
  import ocdac_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // serial lines toward the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  ////////////////////////////////////////////////////////////////////////////
  // idle: clock parked low, select high
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // n clocks msb first; short n is used on purpose for refused and wake frames
  task automatic frame(input int n, input logic [FRAME_W-1:0] tx,
                       output logic [FRAME_W-1:0] rx);
    rx = '0;
    @(negedge sys_clk_i);
    cs_n_o = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    for (int k = 0; k < n; k++)
    begin
      sdi_o = tx[FRAME_W-1-k];
      sclk_o = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      rx[FRAME_W-1-k] = sdo_i; // late in the high phase, after the rise moved it
      sclk_o = 1'b0;
      repeat (2) @(negedge sys_clk_i);
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // a released line must not keep showing its last bit
    repeat (3) @(negedge sys_clk_i);
  endtask
endmodule // ocdac_host
`default_nettype wire

// ### tb/test_ocdac_regs.sv
// self-checking bench for the octal converter register bank
`timescale 1ns/100ps
`default_nettype none
module test_ocdac_regs
  import ocdac_pkg::*;
;
  logic sys_clk, nrst_n, sclk, cs_n, sdi, sdo, resume_n, load_n, sleep_st;
  logic [DATA_W-1:0] latch [NCH];
  int bad_count = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////
  // device and host
  ocdac_regs i_dut (.sys_clk_i(sys_clk), .nrst_i(nrst_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .resume_pin_n_i(resume_n), .load_n_i(load_n),
    .chan_latch_o(latch), .serial_sleep_o(sleep_st));
  ocdac_host i_host (.sys_clk_i(sys_clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo));
  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // shared compare, bus and latch helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [23:0] rx;
    i_host.frame(24, {3'h0, a, d}, rx);
  endtask
  // read data only appears in the following frame, which reads an unmapped place
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    logic [23:0] rx;
    i_host.frame(24, {3'h4, a, 16'h0000}, rx);
    i_host.frame(24, {3'h4, 5'h05, 16'h0000}, rx);
    chk(rx, {RD_PAD, exp});
  endtask
  task automatic load_all();
    load_n = 1'b0;
    @(negedge sys_clk);
    load_n = 1'b1;
  endtask
  task automatic lchk(input int ch, input logic [15:0] exp);
    chk({8'h00, latch[ch]}, {8'h00, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < NCH; i++)
    begin
      rdchk({REGION_CODE, 3'(i)}, 16'h0000);
      rdchk({REGION_OFFSET, 3'(i)}, 16'h0000);
      rdchk({REGION_GAIN, 3'(i)}, 16'h8000);
      lchk(i, 16'h0000);
    end
    rdchk(ADDR_SLEEP_CTRL, 16'h0000);
  endtask
  task automatic t_regs();
    wr({REGION_OFFSET, 3'h4}, 16'h8000);
    wr({REGION_OFFSET, 3'h5}, 16'h7fff);
    wr({REGION_GAIN, 3'h6}, 16'hffff);
    wr({REGION_GAIN, 3'h7}, 16'h0000);
    wr(5'h05, 16'hbeef);
    rdchk({REGION_OFFSET, 3'h4}, 16'h8000);
    rdchk({REGION_OFFSET, 3'h5}, 16'h7fff);
    rdchk({REGION_GAIN, 3'h6}, 16'hffff);
    rdchk({REGION_GAIN, 3'h7}, 16'h0000);
    rdchk(5'h05, 16'h0000);
  endtask
  task automatic t_bcast();
    wr(ADDR_BROADCAST, 16'ha5c3);
    for (int i = 0; i < NCH; i++)
      rdchk({REGION_CODE, 3'(i)}, 16'ha5c3);
    rdchk(ADDR_BROADCAST, 16'h0000);
    lchk(7, 16'h0000);
    load_all();
    for (int i = 0; i < NCH; i++)
      lchk(i, 16'ha5c3);
  endtask
  // gain coefficient is one half plus code over 65536; values picked to divide exactly
  task automatic t_engine();
    wr(ADDR_CONFIG, 16'h0100);
    wr(ADDR_BROADCAST, 16'h5555);
    rdchk({REGION_CODE, 3'h4}, 16'ha5c3);
    wr({REGION_CODE, 3'h0}, 16'h1000);
    wr({REGION_GAIN, 3'h0}, 16'hc000);
    wr({REGION_OFFSET, 3'h0}, 16'h0010);
    wr({REGION_CODE, 3'h1}, 16'h2000);
    wr({REGION_GAIN, 3'h1}, 16'h0000);
    wr({REGION_CODE, 3'h2}, 16'h0100);
    wr({REGION_OFFSET, 3'h2}, 16'hfe00);
    wr({REGION_CODE, 3'h3}, 16'hffff);
    wr({REGION_OFFSET, 3'h3}, 16'h0001);
    rdchk({REGION_CODE, 3'h0}, 16'h1000);
    load_all();
    lchk(0, 16'h1410);
    lchk(1, 16'h1000);
    lchk(2, 16'h0000);
    lchk(3, 16'hffff);
    wr(ADDR_CONFIG, 16'h0010);
  endtask
  task automatic t_sleep();
    logic [23:0] rx;
    wr(ADDR_SLEEP_CTRL, 16'h8000);
    chk({23'h0, sleep_st}, 24'h000001);
    i_host.frame(24, 24'h3c5a96, rx);
    chk(rx, 24'h3c5a96);
    i_host.frame(2, 24'hffffff, rx);
    chk({23'h0, sleep_st}, 24'h000001);
    i_host.frame(1, 24'hffffff, rx);
    chk({23'h0, sleep_st}, 24'h000000);
    rdchk({REGION_GAIN, 3'h4}, 16'h8000);
    wr(ADDR_SLEEP_CTRL, 16'h8000);
    resume_n = 1'b0;
    @(negedge sys_clk);
    chk({23'h0, sleep_st}, 24'h000000);
    wr(ADDR_SLEEP_CTRL, 16'h8000);
    chk({23'h0, sleep_st}, 24'h000000);
    resume_n = 1'b1;
  endtask
  task automatic t_rst2();
    wr(ADDR_SLEEP_CTRL, 16'h8000);
    nrst_n = 1'b0;
    @(negedge sys_clk);
    chk({23'h0, sleep_st}, 24'h000000);
    lchk(0, 16'h0000);
    nrst_n = 1'b1;
    rdchk({REGION_CODE, 3'h0}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    nrst_n = 1'b0;
    resume_n = 1'b1;
    load_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    nrst_n = 1'b1;
    t_reset();
    t_regs();
    t_bcast();
    t_engine();
    t_sleep();
    t_rst2();
    end_of_test();
  end
endmodule // test_ocdac_regs
`default_nettype wire
